/* File: osc_ctrl_pkg.sv */
// package: constants, modes and carriers for the oscillator control block
package osc_ctrl_pkg;

  // register byte offsets on the axi4-lite port
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_TRIM = 4'h4;

  // oscillator_control field positions
  localparam int FREQ_SEL_LSB = 4;
  localparam int LOCKED_BIT = 3;
  localparam int STABLE_BIT = 2;
  localparam int TRIM_WIDTH = 6;

  // values after reset
  localparam logic [1:0] FREQ_SEL_RESET = 2'h2;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // start-up oscillation count
  localparam int STARTUP_COUNT = 1024;
  localparam int STARTUP_CNT_W = 11;

  // selected frequency in units of 62.5 khz, before the postscaler
  localparam logic [8:0] PLL_BASE_UNITS = 9'h100;
  localparam logic [8:0] RC_BASE_UNITS = 9'h008;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // configuration code of the oscillator mode
  typedef enum logic [2:0] {
    MODE_LOW_POWER_RES = 3'h0,
    MODE_MEDIUM_RES = 3'h1,
    MODE_HIGH_SPEED_RES = 3'h2,
    MODE_EXT_CLOCK = 3'h3,
    MODE_INT_IO = 3'h4,
    MODE_INT_CLOCK_OUTPUT = 3'h5,
    MODE_RC_IO = 3'h6,
    MODE_RC_CLOCK_OUTPUT = 3'h7
  } osc_mode_e;

  // configuration word bits that this block reads
  typedef struct packed {
    osc_mode_e mode;
    logic pll_option;
    logic power_up_timer_en;
  } osc_cfg_s;

  // general-purpose request for the second oscillator pin
  typedef struct packed {
    logic out;
    logic drive;
  } gpio_req_s;

endpackage

/* File: startup_oscillation_counter.sv */
// file holds the start-up timer that counts oscillations on the input pin
`timescale 1ns/1ps
module startup_oscillation_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_input_pin,
  input wire logic start,
  output logic done,
  output logic osc_edge
);
  import osc_ctrl_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edge_p;
    logic running;
    logic done;
    logic [STARTUP_CNT_W-1:0] count;
  } cnt_state_s;

  cnt_state_s st_ff;
  cnt_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // first stage is read by the second stage only
    nxt_st.sync1 = osc_input_pin;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    nxt_st.edge_p = st_ff.sync2 & ~st_ff.prev;
    if (start) begin
      nxt_st.running = 1'b1;
      nxt_st.done = 1'b0;
      nxt_st.count = '0;
    end else if (st_ff.running && st_ff.edge_p) begin
      // a stopped source just holds the count, nothing times out
      if (st_ff.count == STARTUP_CNT_W'(STARTUP_COUNT - 1)) begin
        nxt_st.running = 1'b0;
        nxt_st.done = 1'b1;
      end
      nxt_st.count = st_ff.count + STARTUP_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign osc_edge = st_ff.edge_p;
endmodule

/* File: osc_select_tune_startup.sv */
// file holds the oscillator select, trim and start-up control block
//
// Contract
// - pll on: codes 11..00 give 16,8,4,2 mhz
// - pll off: codes give 500,250,125,62.5 khz
// - frequency select in bits 5:4, resets to 10
// - bit 3 reads lock within 2 percent
// - bit 2 reads stable to 0.5 percent
// - unimplemented bits always read zero
// - six-bit signed trim, reset zero, read/write
// - zero trim is factory frequency, sign sets direction
// - trim applies at once, no completion flag
// - resonator modes count 1024 input oscillations
// - count after reset, power-up timer, every wake
// - core stays suspended while counting
// - external clock mode frees second pin for io
// - external clock mode skips start-up count
// - fully static; stopped clock just halts state
// - resonator modes pick low, medium, high gain
// - three-bit mode decode of all eight modes
// - pll option picks 16 mhz or 500 khz source
// - frequency select change needs no start-up delay
// - internal clock-out mode drives frequency over 4
`timescale 1ns/1ps
module osc_select_tune_startup (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration straps, stable while running
  input wire osc_ctrl_pkg::osc_cfg_s osc_cfg,
  // analog side of the internal oscillator, asynchronous
  input wire logic internal_osc_locked,
  input wire logic internal_osc_stable,
  // one pulse per internal oscillator cycle, same clock domain
  input wire logic internal_osc_tick,
  // power-up timer expiry, asynchronous level
  input wire logic power_up_timer_done,
  // wake from sleep, one-cycle pulse from the core
  input wire logic wake_from_sleep,
  // oscillator pins
  input wire logic osc_input_pin,
  input wire logic osc_second_pin_in,
  output logic osc_second_pin_out,
  output logic osc_second_pin_oe_n,
  input wire osc_ctrl_pkg::gpio_req_s gpio_req,
  output logic gpio_in,
  // to the oscillator and core
  output logic [1:0] amp_gain,
  output logic amp_enable,
  output logic [5:0] trim_value,
  output logic [8:0] sys_freq_units,
  output logic sys_clk_tick,
  output logic core_hold
);
  import osc_ctrl_pkg::*;

  typedef enum logic [1:0] {
    SU_POWER_WAIT,
    SU_COUNT,
    SU_RUN
  } startup_e;

  typedef struct packed {
    // axi write side
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [3:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    // axi read side
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
    // registers
    logic [1:0] freq_sel;
    logic [5:0] trim;
    // synchronisers
    logic lock_s1;
    logic lock_s2;
    logic stab_s1;
    logic stab_s2;
    logic pwr_s1;
    logic pwr_s2;
    logic pin_s1;
    logic pin_s2;
    // clocking
    startup_e su;
    logic count_start;
    logic hold;
    logic [2:0] post_cnt;
    logic sys_tick;
    logic clock_output_half;
    logic clock_output;
    logic [8:0] freq_units;
    logic [1:0] gain;
    logic amp_en;
    logic pin_out;
    logic pin_oe_n;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic count_done;
  logic osc_edge;

  startup_oscillation_counter u_startup (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_input_pin(osc_input_pin),
    .start(st_ff.count_start),
    .done(count_done),
    .osc_edge(osc_edge)
  );

  // mode classes
  logic is_resonator;
  logic is_internal;
  logic pin_free;
  logic clock_output_mode;
  logic src_tick;
  logic [2:0] post_max;
  logic [7:0] ctrl_read;

  always_comb begin
    is_resonator = 1'b0;
    is_internal = 1'b0;
    pin_free = 1'b0;
    clock_output_mode = 1'b0;
    unique case (osc_cfg.mode)
      MODE_LOW_POWER_RES, MODE_MEDIUM_RES, MODE_HIGH_SPEED_RES: begin
        is_resonator = 1'b1;
      end
      MODE_EXT_CLOCK: begin
        pin_free = 1'b1;
      end
      MODE_INT_IO: begin
        is_internal = 1'b1;
        pin_free = 1'b1;
      end
      MODE_INT_CLOCK_OUTPUT: begin
        is_internal = 1'b1;
        clock_output_mode = 1'b1;
      end
      MODE_RC_IO: begin
        pin_free = 1'b1;
      end
      MODE_RC_CLOCK_OUTPUT: begin
        clock_output_mode = 1'b1;
      end
    endcase
  end

  // the postscaler divides one running source, so a new select is live
  // on the next source tick with no restart
  always_comb begin
    unique case (st_ff.freq_sel)
      2'h3: post_max = 3'h0;
      2'h2: post_max = 3'h1;
      2'h1: post_max = 3'h3;
      2'h0: post_max = 3'h7;
    endcase
  end

  assign src_tick = is_internal ? internal_osc_tick : osc_edge;

  assign ctrl_read = {2'h0, st_ff.freq_sel, st_ff.lock_s2,
                      st_ff.stab_s2, 2'h0};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.count_start = 1'b0;

    // status inputs pass two flops before anyone reads them
    nxt_st.lock_s1 = internal_osc_locked;
    nxt_st.lock_s2 = st_ff.lock_s1;
    nxt_st.stab_s1 = internal_osc_stable;
    nxt_st.stab_s2 = st_ff.stab_s1;
    nxt_st.pwr_s1 = power_up_timer_done;
    nxt_st.pwr_s2 = st_ff.pwr_s1;
    nxt_st.pin_s1 = osc_second_pin_in;
    nxt_st.pin_s2 = st_ff.pin_s1;

    // write address and data may arrive in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.awready = 1'b0;
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.wready = 1'b0;
      nxt_st.w_held = 1'b1;
      nxt_st.wbyte = s_axi_wdata[7:0];
      nxt_st.wlane = s_axi_wstrb[0];
    end
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = AXI_OKAY;
      unique case (st_ff.awaddr)
        OFS_CONTROL: begin
          // status bits are not stored, so writes to them vanish
          if (st_ff.wlane) begin
            nxt_st.freq_sel = st_ff.wbyte[FREQ_SEL_LSB +: 2];
          end
        end
        OFS_TRIM: begin
          if (st_ff.wlane) begin
            nxt_st.trim = st_ff.wbyte[TRIM_WIDTH-1:0];
          end
        end
        default: begin
          nxt_st.bresp = AXI_SLVERR;
        end
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    // read: one cycle from address to data
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = AXI_OKAY;
      unique case (s_axi_araddr)
        OFS_CONTROL: nxt_st.rbyte = ctrl_read;
        OFS_TRIM: nxt_st.rbyte = {2'h0, st_ff.trim};
        default: begin
          nxt_st.rbyte = 8'h00;
          nxt_st.rresp = AXI_SLVERR;
        end
      endcase
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // start-up sequencing
    unique case (st_ff.su)
      SU_POWER_WAIT: begin
        nxt_st.hold = 1'b1;
        if (!is_resonator) begin
          nxt_st.su = SU_RUN;
          nxt_st.hold = 1'b0;
        end else if (!osc_cfg.power_up_timer_en || st_ff.pwr_s2) begin
          nxt_st.su = SU_COUNT;
          nxt_st.count_start = 1'b1;
        end
      end
      SU_COUNT: begin
        nxt_st.hold = 1'b1;
        if (count_done && !st_ff.count_start) begin
          nxt_st.su = SU_RUN;
          nxt_st.hold = 1'b0;
        end
      end
      SU_RUN: begin
        if (wake_from_sleep && is_resonator) begin
          nxt_st.su = SU_COUNT;
          nxt_st.count_start = 1'b1;
          nxt_st.hold = 1'b1;
        end
      end
    endcase

    // postscaler and clock output; a stalled source just freezes here
    nxt_st.sys_tick = 1'b0;
    if (src_tick) begin
      if (!is_internal || st_ff.post_cnt >= post_max) begin
        nxt_st.post_cnt = 3'h0;
        nxt_st.sys_tick = 1'b1;
        nxt_st.clock_output_half = ~st_ff.clock_output_half;
        if (st_ff.clock_output_half) begin
          nxt_st.clock_output = ~st_ff.clock_output;
        end
      end else begin
        nxt_st.post_cnt = st_ff.post_cnt + 3'h1;
      end
    end

    nxt_st.freq_units = (osc_cfg.pll_option ? PLL_BASE_UNITS
                         : RC_BASE_UNITS) >> (2'h3 - st_ff.freq_sel);

    // amplifier gain follows the resonator choice
    nxt_st.amp_en = is_resonator;
    unique case (osc_cfg.mode)
      MODE_MEDIUM_RES: nxt_st.gain = 2'h1;
      MODE_HIGH_SPEED_RES: nxt_st.gain = 2'h2;
      default: nxt_st.gain = 2'h0;
    endcase

    // second pin: clock out, io, or left to the amplifier
    if (clock_output_mode) begin
      nxt_st.pin_out = st_ff.clock_output;
      nxt_st.pin_oe_n = 1'b0;
    end else if (pin_free) begin
      nxt_st.pin_out = gpio_req.out;
      nxt_st.pin_oe_n = ~gpio_req.drive;
    end else begin
      nxt_st.pin_out = 1'b0;
      nxt_st.pin_oe_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.freq_sel <= FREQ_SEL_RESET;
      st_ff.trim <= TRIM_RESET;
      st_ff.su <= SU_POWER_WAIT;
      st_ff.hold <= 1'b1;
      st_ff.pin_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = {24'h000000, st_ff.rbyte};
  // trim is a signed code: zero is factory frequency, 1f fastest, 20 slowest
  assign trim_value = st_ff.trim;
  assign sys_freq_units = st_ff.freq_units;
  assign sys_clk_tick = st_ff.sys_tick;
  assign core_hold = st_ff.hold;
  assign amp_gain = st_ff.gain;
  assign amp_enable = st_ff.amp_en;
  assign osc_second_pin_out = st_ff.pin_out;
  assign osc_second_pin_oe_n = st_ff.pin_oe_n;
  assign gpio_in = st_ff.pin_s2;
endmodule

/* File: osc_source.sv */
// external clock source model driving the oscillator input pin
`timescale 1ns/1ps
module osc_source #(
  parameter int HALF = 3
) (
  input wire logic aclk,
  input wire logic run,
  output logic pin
);
  int ph;
  // a stopped source stands low, so no stray edge reaches the counter
  always_ff @(posedge aclk) begin
    if (!run) begin
      ph <= 0;
      pin <= 1'b0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      pin <= ~pin;
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

/* File: osc_select_tune_startup_checker.sv */
// concurrent checks on the oscillator control block ports
`timescale 1ns/1ps
module osc_select_tune_startup_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire osc_ctrl_pkg::osc_cfg_s osc_cfg,
  input wire osc_ctrl_pkg::gpio_req_s gpio_req,
  input wire logic wake_from_sleep,
  input wire logic osc_second_pin_oe_n,
  input wire logic [1:0] amp_gain,
  input wire logic amp_enable,
  input wire logic [8:0] sys_freq_units,
  input wire logic core_hold
);
  import osc_ctrl_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic res_mode;
  logic free_mode;
  assign res_mode = osc_cfg.mode <= MODE_HIGH_SPEED_RES;
  assign free_mode = osc_cfg.mode inside {MODE_EXT_CLOCK, MODE_INT_IO,
                                          MODE_RC_IO};
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_write_busy: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("write address not refused");
  a_freq_legal: assert property ($past(aresetn) && $past(aresetn, 2)
    |-> (osc_cfg.pll_option ? sys_freq_units inside {9'h100, 9'h080,
    9'h040, 9'h020} : sys_freq_units inside {9'h008, 9'h004, 9'h002,
    9'h001})) else $error("illegal frequency");
  a_gain_mode: assert property ($past(aresetn) && $past(aresetn, 2)
    |-> amp_gain == (res_mode ? osc_cfg.mode[1:0] : 2'h0)
    && amp_enable == res_mode) else $error("gain does not follow mode");
  a_ext_no_hold: assert property (osc_cfg.mode == MODE_EXT_CLOCK
    && !core_hold |=> !core_hold) else $error("hold in external mode");
  a_pin_free: assert property (free_mode
    |=> osc_second_pin_oe_n == !$past(gpio_req.drive))
    else $error("free pin not handed to io");
  a_wake_hold: assert property (res_mode && wake_from_sleep
    && !core_hold |=> core_hold) else $error("wake did not hold core");
endmodule

bind osc_select_tune_startup osc_select_tune_startup_checker u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .osc_cfg, .gpio_req,
  .wake_from_sleep, .osc_second_pin_oe_n, .amp_gain, .amp_enable,
  .sys_freq_units, .core_hold
);

/* File: osc_select_tune_startup_bench.sv */
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
module osc_select_tune_startup_bench;
  import osc_ctrl_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, osc_second_pin_out, osc_second_pin_oe_n, gpio_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, amp_gain;
  logic amp_enable, sys_clk_tick, core_hold, osc_input_pin;
  logic [5:0] trim_value;
  logic [8:0] sys_freq_units;
  logic internal_osc_locked = 1'b0, internal_osc_stable = 1'b0;
  logic internal_osc_tick = 1'b0, power_up_timer_done = 1'b0;
  logic wake_from_sleep = 1'b0, osc_second_pin_in = 1'b0;
  osc_cfg_s osc_cfg = '{MODE_INT_IO, 1'b1, 1'b0};
  gpio_req_s gpio_req = '0;
  int errors = 0;
  int checks_done = 0;

  osc_select_tune_startup u_osc_select_tune_startup (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .osc_cfg(osc_cfg),
    .internal_osc_locked(internal_osc_locked),
    .internal_osc_stable(internal_osc_stable),
    .internal_osc_tick(internal_osc_tick),
    .power_up_timer_done(power_up_timer_done),
    .wake_from_sleep(wake_from_sleep), .osc_input_pin(osc_input_pin),
    .osc_second_pin_in(osc_second_pin_in),
    .osc_second_pin_out(osc_second_pin_out),
    .osc_second_pin_oe_n(osc_second_pin_oe_n), .gpio_req(gpio_req),
    .gpio_in(gpio_in), .amp_gain(amp_gain), .amp_enable(amp_enable),
    .trim_value(trim_value), .sys_freq_units(sys_freq_units),
    .sys_clk_tick(sys_clk_tick), .core_hold(core_hold)
  );
  osc_source u_osc_source (.aclk(aclk), .run(run), .pin(osc_input_pin));

  always #5 aclk = ~aclk;
  always @(posedge aclk) internal_osc_tick <= ~internal_osc_tick;

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // each channel is judged and released at the rising edge that takes it;
  // no wait limit here, the watchdog ends a hung bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rs, xr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    xr = (a == OFS_CONTROL || a == OFS_TRIM) ? AXI_OKAY : AXI_SLVERR;
    chk(d, e);
    chk(32'(rs), 32'(xr));
  endtask

  // counts system ticks and clock-out rises over n cycles
  task automatic ticks(input int n, output int t, output int k);
    logic p;
    t = 0;
    k = 0;
    @(posedge aclk);
    p = osc_second_pin_out;
    repeat (n) begin
      @(posedge aclk);
      t += int'(sys_clk_tick);
      k += int'(osc_second_pin_out && !p);
      p = osc_second_pin_out;
    end
  endtask

  task automatic do_reset(input osc_mode_e m, input logic pll,
                          input logic pw);
    @(posedge aclk);
    aresetn <= 1'b0;
    osc_cfg <= '{m, pll, pw};
    cyc(12);
    aresetn <= 1'b1;
  endtask

  // one rising pin edge every six cycles, source halted afterwards
  task automatic edges(input int n);
    @(posedge aclk);
    run <= 1'b1;
    cyc(6 * n);
    run <= 1'b0;
    cyc(8);
  endtask

  task automatic wake();
    wake_from_sleep <= 1'b1;
    @(posedge aclk);
    wake_from_sleep <= 1'b0;
    cyc(2);
  endtask

  task automatic freq_loop(input logic [8:0] base);
    logic [1:0] r;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CONTROL, 8'(s << 4), r);
      cyc(3);
      chk(32'(sys_freq_units), 32'(base >> (3 - s)));
    end
  endtask

  task automatic test_done(input string n);
    $display("end of test %s", n);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    logic [1:0] r;
    int t, k;
    do_reset(MODE_INT_IO, 1'b1, 1'b0);
    cyc(2);
    rd_chk(OFS_CONTROL, 32'h20);
    rd_chk(OFS_TRIM, 32'h00);
    wr(OFS_CONTROL, 8'hFF, r);
    rd_chk(OFS_CONTROL, 32'h30);
    internal_osc_locked <= 1'b1;
    internal_osc_stable <= 1'b1;
    cyc(5);
    rd_chk(OFS_CONTROL, 32'h3C);
    wr(OFS_TRIM, 8'hE0, r);
    rd_chk(OFS_TRIM, 32'h20);
    chk(32'(trim_value), 32'h20);
    wr(4'h8, 8'h55, r);
    chk(32'(r), 32'(AXI_SLVERR));
    rd_chk(4'h8, 32'h0);
    rd_chk(OFS_TRIM, 32'h20);
    freq_loop(PLL_BASE_UNITS);
    gpio_req <= '{1'b1, 1'b1};
    osc_second_pin_in <= 1'b1;
    cyc(4);
    chk(32'({osc_second_pin_oe_n, osc_second_pin_out, gpio_in,
             core_hold}), 32'h6);
    test_done("registers");
    do_reset(MODE_INT_IO, 1'b0, 1'b0);
    freq_loop(RC_BASE_UNITS);
    test_done("no pll");
    // internal tick every 2 cycles; select 10 halves it, pin divides by 4
    do_reset(MODE_INT_CLOCK_OUTPUT, 1'b1, 1'b0);
    cyc(4);
    ticks(64, t, k);
    chk(32'(t), 32'd16);
    chk(32'(k), 32'd4);
    chk(32'(osc_second_pin_oe_n), 32'h0);
    wr(OFS_CONTROL, 8'h30, r);
    ticks(64, t, k);
    chk(32'(t), 32'd32);
    chk(32'(k), 32'd8);
    test_done("clock out");
    do_reset(MODE_EXT_CLOCK, 1'b1, 1'b0);
    cyc(4);
    chk(32'(core_hold), 32'h0);
    wake();
    chk(32'({core_hold, amp_enable}), 32'h0);
    // one pin rise every 6 cycles; a stopped source must freeze the ticks
    run <= 1'b1;
    cyc(12);
    ticks(60, t, k);
    chk(32'(t), 32'd10);
    run <= 1'b0;
    cyc(8);
    ticks(60, t, k);
    chk(32'(t), 32'd0);
    run <= 1'b1;
    cyc(12);
    ticks(60, t, k);
    chk(32'(t), 32'd10);
    run <= 1'b0;
    cyc(8);
    test_done("external clock");
    do_reset(MODE_HIGH_SPEED_RES, 1'b1, 1'b1);
    cyc(2);
    chk(32'({core_hold, amp_enable, amp_gain}), 32'hE);
    edges(1100);
    chk(32'(core_hold), 32'h1);
    power_up_timer_done <= 1'b1;
    cyc(4);
    edges(1023);
    chk(32'(core_hold), 32'h1);
    edges(1);
    chk(32'(core_hold), 32'h0);
    wake();
    chk(32'(core_hold), 32'h1);
    edges(1024);
    chk(32'(core_hold), 32'h0);
    test_done("start-up");
    end_of_test();
  end

  // whole run is near 20000 cycles
  initial begin
    cyc(60000);
    errors++;
    end_of_test();
  end
endmodule
